/* pps_cmd_model.sv */
// Command source model: keys, external contacts and link host
`timescale 1ns/1ps
`default_nettype none
module pps_cmd_model (
   // Clock
   input  wire logic       mclk,
   // Command pulses, one bit per command
   output logic      [7:0] pulse
);
   // ***********************************************
   // Command pulses
   // ***********************************************
   // All sources idle at time zero
   initial pulse = 8'h00;
   // One-cycle pulse launched off the falling edge, so the
   // sequencer sees it settled at the next rising edge
   task automatic press(input int k);
      @(negedge mclk);
      pulse[k] = 1'b1;
      @(negedge mclk);
      pulse[k] = 1'b0;
   endtask
endmodule // pps_cmd_model
`default_nettype wire

/* pps_params.svh */
// Constants for the program pattern segment sequencer
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
// ***************************************************************
// Timing
// ***************************************************************
`define PPS_CLK_HZ        100000000
`define PPS_TICK_TIME_S   1
`define PPS_TICK_CYC      (`PPS_CLK_HZ * `PPS_TICK_TIME_S)
`define PPS_END_TIME_S    5
`define PPS_END_SECS      8'h05
`define PPS_DELAY_MAX_S   32'h00057e3f
// ***************************************************************
// Widths and field values
// ***************************************************************
`define PPS_SEGW          5
`define PPS_SECW          32
`define PPS_NEV           16
`define PPS_SEG_FIRST     5'h01
`define PPS_SW_CONT       2'h0
`define PPS_SW_HOLD       2'h1
`define PPS_SW_LOCAL      2'h2
`define PPS_SW_RESET      2'h3
`define PPS_ONE           32'h00000001
`define PPS_ZERO          32'h00000000
`endif

/* pps_pattern_decode.sv */
// Pattern number decode from six contact inputs, binary or BCD
`timescale 1ns/1ps
`default_nettype none
module pps_pattern_decode (
   // Contacts
   input  wire logic [5:0] sel_in,
   input  wire logic       bcd_mode,
   // Result
   output logic      [6:0] pattern
);
   // ***************************************************************
   // Decode
   // ***************************************************************
   // BCD: low four bits are units, top two bits are tens
   wire [6:0] bin_val = {1'b0, sel_in};
   wire [6:0] tens    = {5'h00, sel_in[5:4]};
   wire [6:0] bcd_val = 7'((tens << 3) + (tens << 1)) + {3'h0, sel_in[3:0]};
   assign pattern = bcd_mode ? bcd_val : bin_val;
endmodule // pps_pattern_decode
`default_nettype wire

/* pps_pkg.sv */
// Type definitions for the program pattern segment sequencer
`default_nettype none
package pps_pkg;
   // Run state, one-hot
   typedef enum logic [4:0] {
      PPS_IDLE  = 5'b00001,
      PPS_DELAY = 5'b00010,
      PPS_RUN   = 5'b00100,
      PPS_HOLD  = 5'b01000,
      PPS_LOCAL = 5'b10000
   } pps_state_t;
endpackage
`default_nettype wire

/* pps_sequencer.sv */
// Program pattern segment sequencer top
// Contract
// - Pattern from contacts, binary or BCD
// - Repeat section: start, end, count, unlimited
// - Only one repeat range tracked
// - Repeat off or past end: no repeat
// - Change below start restarts repeat counting
// - Count change keeps done passes
// - Unlimited to finite counts from change
// - Jump back forces time events off
// - PV start again at each repeat
// - Start delay up to 99:59:59, locked running
// - Delay rejects hold and advance
// - Run begins at chosen start segment
// - Mid start uses start mode rules
// - Hold freezes segment timer
// - Hold edits final SP, remaining time
// - Time ramp refuses remaining-time-only edit
// - Release, run or advance leaves hold
// - Hold and edits shift end, events
// - Shortened time fires expired events
// - Last advance: local or reset
// - Advance: repeat, next segment, clears hold
// - Normal end pulses contact 5 s
// - Hold release at last segment stops
`timescale 1ns/1ps
`default_nettype none
`include "pps_params.svh"
module pps_sequencer (
   // Clock, reset, enable
   input  wire logic                   MCLK,
   input  wire logic                   SRST,
   input  wire logic                   CE,
   // Pattern select contacts
   input  wire logic [5:0]             PATTERN_SELECT_INPUTS,
   input  wire logic                   BCD_MODE,
   // Commands (one-cycle pulses)
   input  wire logic                   RUN_REQ,
   input  wire logic                   STOP_REQ,
   input  wire logic                   HOLD_REQ,
   input  wire logic                   RELEASE_REQ,
   input  wire logic                   ADVANCE_REQ,
   // Pattern configuration
   input  wire logic [`PPS_SEGW-1:0]   START_SEG,
   input  wire logic [`PPS_SEGW-1:0]   LAST_SEG,
   input  wire logic [`PPS_SECW-1:0]   SEG_TIME,
   input  wire logic [1:0]             SEG_SWITCH,
   input  wire logic                   SEG_TIME_RAMP,
   input  wire logic [1:0]             START_MODE,
   input  wire logic [`PPS_SECW-1:0]   START_DELAY,
   // Repeat section
   input  wire logic                   REP_ON,
   input  wire logic [`PPS_SEGW-1:0]   REP_START,
   input  wire logic [`PPS_SEGW-1:0]   REP_END,
   input  wire logic [7:0]             REP_COUNT,
   input  wire logic                   REP_INF,
   input  wire logic                   REP_CHANGE,
   // Time events of the current segment
   input  wire logic [`PPS_SECW-1:0]   EV_ON_TIME [`PPS_NEV],
   input  wire logic [`PPS_SECW-1:0]   EV_OFF_TIME [`PPS_NEV],
   // Hold edits
   input  wire logic                   EDIT_FSP,
   input  wire logic                   EDIT_TIME,
   input  wire logic [`PPS_SECW-1:0]   EDIT_REMAIN,
   input  wire logic [`PPS_SECW-1:0]   RECALC_REMAIN,
   // Status
   output logic [6:0]                  PATTERN,
   output logic [`PPS_SEGW-1:0]        SEGMENT,
   output logic [`PPS_SECW-1:0]        SEG_ELAPSED,
   output logic [`PPS_SECW-1:0]        SEG_END,
   output logic [7:0]                  REP_DONE,
   output logic                        RUNNING,
   output logic                        DELAYING,
   output logic                        HOLDING,
   output logic                        LOCAL_MODE,
   output logic                        PV_START,
   output logic [`PPS_NEV-1:0]         TIME_EVENT,
   output logic                        PATTERN_END,
   output logic                        END_REPORT
);
   import pps_pkg::*;
   default clocking @(posedge MCLK); endclocking  // Checks on the one clock
   default disable iff (SRST);                     // Checks rest in reset
   // ***************************************************************
   // State and counters
   // ***************************************************************
   pps_state_t                state;       // Run state
   logic [26:0]               tick_cnt;    // Divider to one second
   logic [`PPS_SECW-1:0]      delay_cnt;   // Start delay remaining
   logic [7:0]                end_cnt;     // Pattern end pulse seconds
   logic                      rep_inf_run; // Unlimited as of last change
   logic [6:0]                pattern_raw; // Decoded contacts
   // ***************************************************************
   // Pattern decode
   // ***************************************************************
   pps_pattern_decode u_decode (
      .sel_in   (PATTERN_SELECT_INPUTS),
      .bcd_mode (BCD_MODE),
      .pattern  (pattern_raw));
   // ***************************************************************
   // Decode of conditions
   // ***************************************************************
   // One-second strobe; held time does not run
   wire sec_tick   = (tick_cnt == 27'(`PPS_TICK_CYC - 1));
   wire st_idle    = (state == PPS_IDLE) || (state == PPS_LOCAL);
   wire st_delay   = (state == PPS_DELAY);
   wire st_run     = (state == PPS_RUN);
   wire st_hold    = (state == PPS_HOLD);
   // Delay phase swallows hold and advance
   wire adv_ok     = ADVANCE_REQ && (st_run || st_hold);
   wire hold_ok    = HOLD_REQ && st_run;
   wire rel_ok     = st_hold && (RELEASE_REQ || RUN_REQ);
   wire at_last    = (SEGMENT == LAST_SEG);
   wire at_rep_end = REP_ON && (SEGMENT == REP_END);
   // Finite pass budget left; unlimited always repeats
   wire passes_left = REP_INF || (REP_DONE < REP_COUNT);
   wire seg_done   = st_run && sec_tick && (SEG_ELAPSED + `PPS_ONE >= SEG_END);
   wire step       = seg_done || adv_ok;
   // Repeat jump taken at the section end
   wire do_repeat  = step && at_rep_end && passes_left;
   // Natural end of the last segment
   wire nat_end    = seg_done && at_last && !do_repeat;
   wire adv_end    = adv_ok && at_last && !do_repeat;
   // Remaining time alone locked on time-ramp segments
   wire time_edit  = st_hold && EDIT_TIME && !EDIT_FSP &&
                     !SEG_TIME_RAMP;
   wire fsp_edit   = st_hold && EDIT_FSP;
   // Edits shift end relative to now
   wire [`PPS_SECW-1:0] new_end = SEG_ELAPSED +
        (fsp_edit && SEG_TIME_RAMP ? RECALC_REMAIN : EDIT_REMAIN);
   // Full width: a one-bit load would cut every delay to a second
   wire [`PPS_SECW-1:0] delay_load = (START_DELAY > `PPS_DELAY_MAX_S) ?
                     `PPS_DELAY_MAX_S : START_DELAY;
   // ***************************************************************
   // Second divider
   // ***************************************************************
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tick_cnt <= 27'h0;
      end else if (CE) begin
         tick_cnt <= sec_tick ? 27'h0 : tick_cnt + 27'h1;
      end
   end
   // ***************************************************************
   // Sequencer state
   // ***************************************************************
   // Keeps elapsed time frozen while held so end and events move late
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state       <= PPS_IDLE;
         SEGMENT     <= `PPS_SEG_FIRST;
         SEG_ELAPSED <= `PPS_ZERO;
         SEG_END     <= `PPS_ZERO;
         delay_cnt   <= `PPS_ZERO;
         PATTERN     <= 7'h00;
         PV_START    <= 1'b0;
      end else if (CE) begin
         PV_START <= 1'b0;
         unique case (state)
            PPS_IDLE, PPS_LOCAL: begin
               if (RUN_REQ) begin
                  PATTERN   <= pattern_raw;
                  SEGMENT   <= START_SEG;
                  SEG_ELAPSED <= `PPS_ZERO;
                  SEG_END   <= SEG_TIME;
                  delay_cnt <= delay_load;
                  state     <= PPS_DELAY;
               end
            end
            PPS_DELAY: begin
               if (STOP_REQ) begin
                  state <= PPS_IDLE;
               end else if (delay_cnt == `PPS_ZERO) begin
                  state    <= PPS_RUN;
                  PV_START <= (START_MODE != 2'h0);
                  SEG_END  <= SEG_TIME;
               end else if (sec_tick) begin
                  delay_cnt <= delay_cnt - `PPS_ONE;
               end
            end
            PPS_RUN, PPS_HOLD: begin
               if (STOP_REQ) begin
                  state <= PPS_IDLE;
               end else if (adv_end || nat_end) begin
                  state <= (SEG_SWITCH == `PPS_SW_LOCAL) ?
                           PPS_LOCAL : PPS_IDLE;
               end else if (rel_ok && at_last && !ADVANCE_REQ) begin
                  state <= PPS_IDLE;
               end else if (do_repeat) begin
                  SEGMENT     <= REP_START;
                  SEG_ELAPSED <= `PPS_ZERO;
                  SEG_END     <= SEG_TIME;
                  PV_START    <= (START_MODE != 2'h0);
                  state       <= PPS_RUN;
               end else if (step) begin
                  SEGMENT     <= SEGMENT + `PPS_SEGW'(1);
                  SEG_ELAPSED <= `PPS_ZERO;
                  SEG_END     <= SEG_TIME;
                  state       <= PPS_RUN;
               end else if (hold_ok) begin
                  state <= PPS_HOLD;
               end else if (rel_ok) begin
                  state <= PPS_RUN;
               end else if (time_edit || fsp_edit) begin
                  SEG_END <= new_end;
               end else if (st_run && sec_tick) begin
                  SEG_ELAPSED <= SEG_ELAPSED + `PPS_ONE;
               end
            end
            default: state <= PPS_IDLE;
         endcase
      end
   end
   // ***************************************************************
   // Repeat pass counting
   // ***************************************************************
   // One counter only; a single section per pattern
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         REP_DONE    <= 8'h00;
         rep_inf_run <= 1'b0;
      end else if (CE) begin
         if ((st_idle && RUN_REQ) || REP_CHANGE) rep_inf_run <= REP_INF;
         if (st_idle && RUN_REQ) begin
            REP_DONE <= 8'h00;
         end else if (REP_CHANGE && (!REP_ON || SEGMENT > REP_END)) begin
            REP_DONE <= REP_COUNT;
         end else if (REP_CHANGE && SEGMENT < REP_START) begin
            REP_DONE <= 8'h00;
         end else if (REP_CHANGE && rep_inf_run && !REP_INF) begin
            REP_DONE <= 8'h00;
         end else if (do_repeat && !REP_INF) begin
            REP_DONE <= REP_DONE + 8'h01;
         end
      end
   end
   // ***************************************************************
   // Time events
   // ***************************************************************
   // Level from elapsed time; a cut end makes passed events fire now
   genvar gi;
   generate
      for (gi = 0; gi < `PPS_NEV; gi++) begin : g_ev
         wire ev_live = (st_run || st_hold) &&
                        (SEG_ELAPSED >= EV_ON_TIME[gi]) &&
                        (SEG_ELAPSED <  EV_OFF_TIME[gi]);
         // Shortened remaining time: the on point lies past the new end
         wire ev_cut  = time_edit && (EV_ON_TIME[gi] >= new_end) &&
                        (EV_ON_TIME[gi] < SEG_END);
         always_ff @(posedge MCLK) begin
            if (SRST) begin
               TIME_EVENT[gi] <= 1'b0;
            end else if (CE) begin
               if (do_repeat || st_idle) begin
                  TIME_EVENT[gi] <= 1'b0;
               end else if (ev_cut) begin
                  TIME_EVENT[gi] <= 1'b1;
               end else if (!st_hold) begin
                  TIME_EVENT[gi] <= ev_live;
               end
            end
         end
      end
   endgenerate
   // ***************************************************************
   // Pattern end contact and status
   // ***************************************************************
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         end_cnt     <= 8'h00;
         PATTERN_END <= 1'b0;
         END_REPORT  <= 1'b0;
         RUNNING     <= 1'b0;
         DELAYING    <= 1'b0;
         HOLDING     <= 1'b0;
         LOCAL_MODE  <= 1'b0;
      end else if (CE) begin
         END_REPORT <= nat_end && !STOP_REQ;
         if (nat_end && !STOP_REQ) begin
            end_cnt     <= `PPS_END_SECS;
            PATTERN_END <= 1'b1;
         end else if (end_cnt == 8'h00) begin
            PATTERN_END <= 1'b0;
         end else if (sec_tick) begin
            end_cnt     <= end_cnt - 8'h01;
            PATTERN_END <= (end_cnt != 8'h01);
         end
         RUNNING    <= st_run;
         DELAYING   <= st_delay;
         HOLDING    <= st_hold;
         LOCAL_MODE <= (state == PPS_LOCAL);
      end
   end
   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_delay_blocks;
      (st_delay && CE) |=> !st_hold;
   endproperty
   a_delay_blocks: assert property (p_delay_blocks)
      else $error("hold entered during start delay");
   property p_hold_freeze;
      (st_hold && !adv_ok && !rel_ok) |=> $stable(SEG_ELAPSED);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze)
      else $error("segment timer moved during hold");
   property p_repeat_clear;
      (CE && do_repeat && !STOP_REQ) |=> (TIME_EVENT == '0);
   endproperty
   a_repeat_clear: assert property (p_repeat_clear)
      else $error("time events left on at repeat jump");
   property p_start_seg;
      (CE && st_idle && RUN_REQ) |=> (SEGMENT == $past(START_SEG));
   endproperty
   a_start_seg: assert property (p_start_seg)
      else $error("run did not begin at start segment");
   property p_end_pulse;
      (CE && nat_end && !STOP_REQ) |=> PATTERN_END && END_REPORT;
   endproperty
   a_end_pulse: assert property (p_end_pulse)
      else $error("pattern end not signalled");
   property p_stop_no_pulse;
      (CE && STOP_REQ && !PATTERN_END) |=> !PATTERN_END;
   endproperty
   a_stop_no_pulse: assert property (p_stop_no_pulse)
      else $error("end pulse on forced stop");
   property p_adv_last;
      (CE && adv_end && !STOP_REQ) |=> (state != PPS_RUN);
   endproperty
   a_adv_last: assert property (p_adv_last)
      else $error("advance at last segment kept running");
   property p_release_last;
      (CE && rel_ok && at_last && !ADVANCE_REQ) |=> (state == PPS_IDLE);
   endproperty
   a_release_last: assert property (p_release_last)
      else $error("hold release at last segment did not stop");
endmodule // pps_sequencer
`default_nettype wire

/* program_pattern_sequencer_tb.sv */
// Self-checking bench for the program pattern segment sequencer
`timescale 1ns/1ps
`default_nettype none
module program_pattern_sequencer_tb;
   // ***********************************************
   // Stimulus and observed signals
   // ***********************************************
   logic        mclk, srst, bcd, ramp, rep_on, rep_inf;
   logic [5:0]  sel;                          // Pattern contacts
   logic [4:0]  start_seg, last_seg, rep_start, rep_end;
   logic [31:0] seg_time, start_delay, edit_remain, recalc;
   logic [1:0]  seg_switch, start_mode;
   logic [7:0]  rep_count, rep_done;
   logic [31:0] ev_on [16];                   // Event times, static
   logic [31:0] ev_off [16];
   logic [7:0]  pl;                           // Command pulses
   logic [6:0]  pattern;
   logic [4:0]  segment;
   logic [31:0] elapsed, seg_end;
   logic        running, delaying, holding, local_mode, pv_start;
   logic        pattern_end, end_report;
   logic [15:0] time_event;
   int          n_errors, checks, cyc, pv_n;
   // ***********************************************
   // Design and command source
   // ***********************************************
   pps_cmd_model u_op (.mclk(mclk), .pulse(pl));
   pps_sequencer u_dut (.MCLK(mclk), .SRST(srst), .CE(1'b1),
      .PATTERN_SELECT_INPUTS(sel), .BCD_MODE(bcd), .RUN_REQ(pl[0]),
      .STOP_REQ(pl[1]), .HOLD_REQ(pl[2]), .RELEASE_REQ(pl[3]),
      .ADVANCE_REQ(pl[4]), .START_SEG(start_seg), .LAST_SEG(last_seg),
      .SEG_TIME(seg_time), .SEG_SWITCH(seg_switch),
      .SEG_TIME_RAMP(ramp), .START_MODE(start_mode),
      .START_DELAY(start_delay), .REP_ON(rep_on),
      .REP_START(rep_start), .REP_END(rep_end), .REP_COUNT(rep_count),
      .REP_INF(rep_inf), .REP_CHANGE(pl[5]), .EV_ON_TIME(ev_on),
      .EV_OFF_TIME(ev_off), .EDIT_FSP(pl[6]), .EDIT_TIME(pl[7]),
      .EDIT_REMAIN(edit_remain), .RECALC_REMAIN(recalc),
      .PATTERN(pattern), .SEGMENT(segment), .SEG_ELAPSED(elapsed),
      .SEG_END(seg_end), .REP_DONE(rep_done), .RUNNING(running),
      .DELAYING(delaying), .HOLDING(holding), .LOCAL_MODE(local_mode),
      .PV_START(pv_start), .TIME_EVENT(time_event),
      .PATTERN_END(pattern_end), .END_REPORT(end_report));
   // ***********************************************
   // Clock, pulse counter and hang guard
   // ***********************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // PV start pulses last one cycle, so count them as they pass
   always @(posedge mclk) begin
      if (pv_start === 1'b1) pv_n <= pv_n + 1;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ***********************************************
   // Shared tasks
   // ***********************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Pulse a command, then wait past the two-cycle answer
   task automatic cmd(input int k);
      u_op.press(k);
      repeat (3) @(negedge mclk);
   endtask
   task automatic go(input logic [4:0] s);
      start_seg = s;
      cmd(0);
   endtask
   task end_of_test;
      $display("n_errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   // Both weightings, two contact values each
   task automatic t_pattern;
      logic [31:0] want;                      // Pattern number by weighting
      for (int i = 0; i < 4; i++) begin
         bcd = i[1];
         sel = i[0] ? 6'h39 : 6'h25;
         want = i[1] ? (i[0] ? 32'h27 : 32'h19) : {26'h0, sel};
         go(5'h01);
         chk({25'h0, pattern}, want);
         cmd(1);
      end
      bcd = 1'b0;
   endtask
   // Mid start, hold edits and the three ways out of hold
   task automatic t_hold;
      go(5'h03);
      chk(segment, 32'h3);
      chk(running, 32'h1);
      cmd(2);
      chk(holding, 32'h1);
      edit_remain = 32'h14;
      cmd(7);
      chk(seg_end, 32'h14);
      // Event 0 live; events 10..15 lie past the cut end and fire
      chk(time_event, 32'hfc01);
      ramp = 1'b1;
      edit_remain = 32'h46;
      cmd(7);
      chk(seg_end, 32'h14);
      cmd(6);
      chk(seg_end, 32'h1e);
      ramp = 1'b0;
      cmd(3);
      chk(holding, 32'h0);
      cmd(2);
      cmd(0);
      chk(holding, 32'h0);
      cmd(2);
      cmd(4);
      chk(holding, 32'h0);
      chk(segment, 32'h4);
      cmd(1);
   endtask
   // Advance at the last segment under every switching code
   task automatic t_last;
      for (int i = 0; i < 4; i++) begin
         seg_switch = i[1:0];
         go(5'h08);
         cmd(4);
         chk(local_mode, i == 2);
         chk(running, 32'h0);
      end
      seg_switch = 2'h0;
      go(5'h08);
      cmd(2);
      cmd(3);
      chk(running, 32'h0);
      chk(holding, 32'h0);
   endtask
   // Hold and advance refused while the delay counts; stop is forced
   task automatic t_delay;
      start_delay = 32'h0a;
      go(5'h02);
      chk(delaying, 32'h1);
      cmd(2);
      chk(holding, 32'h0);
      cmd(4);
      chk(segment, 32'h2);
      cmd(1);
      chk(delaying, 32'h0);
      chk(pattern_end, 32'h0);
      chk(end_report, 32'h0);
      start_delay = 32'h0;
   endtask
   // Repeat section over segments 2..3 with PV start
   task automatic t_repeat;
      rep_on = 1'b1;
      start_mode = 2'h1;
      pv_n = 0;
      go(5'h02);
      chk(pv_n, 32'h1);
      for (int p = 1; p <= 2; p++) begin
         cmd(4);
         cmd(4);
         chk(segment, 32'h2);
         chk(rep_done, p);
      end
      chk(pv_n, 32'h3);
      cmd(4);
      cmd(4);
      chk(segment, 32'h4);
      cmd(1);
      rep_count = 8'h03;
      go(5'h02);
      cmd(4);
      cmd(4);
      rep_count = 8'h01;
      cmd(5);
      cmd(4);
      cmd(4);
      chk(segment, 32'h4);
      cmd(1);
      go(5'h02);
      cmd(4);
      rep_on = 1'b0;
      cmd(5);
      cmd(4);
      chk(segment, 32'h4);
      cmd(1);
      rep_on = 1'b1;
      rep_count = 8'h02;
      go(5'h02);
      cmd(4);
      cmd(4);
      // Section moved above the current segment: count restarts
      rep_start = 5'h03;
      cmd(5);
      chk(rep_done, 32'h0);
      rep_start = 5'h02;
      cmd(5);
      cmd(4);
      cmd(4);
      chk(rep_done, 32'h1);
      // Unlimited pass leaves the count alone, finite again restarts it
      rep_inf = 1'b1;
      cmd(5);
      cmd(4);
      cmd(4);
      chk(rep_done, 32'h1);
      rep_inf = 1'b0;
      cmd(5);
      chk(rep_done, 32'h0);
      for (int p = 0; p < 2; p++) begin
         cmd(4);
         cmd(4);
         chk(segment, 32'h2);
      end
      cmd(4);
      cmd(4);
      chk(segment, 32'h4);
      cmd(1);
   endtask
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      {bcd, ramp, rep_on, rep_inf, sel} = '0;
      {seg_switch, start_mode, start_delay} = '0;
      {start_seg, last_seg, rep_start, rep_end} = {5'h1, 5'h8, 5'h2, 5'h3};
      {seg_time, edit_remain, recalc} = {32'h64, 32'h0, 32'h1e};
      rep_count = 8'h02;
      for (int i = 0; i < 16; i++) begin
         ev_on[i] = 32'h0a + i;
         ev_off[i] = 32'h20 + i;
      end
      ev_on[0] = 32'h0;                       // Event 0 on from segment start
      {n_errors, checks, cyc, pv_n} = '0;
      srst = 1'b1;
      repeat (2) @(negedge mclk);
      srst = 1'b0;
      @(negedge mclk);
      chk(segment, 32'h1);
      chk(elapsed, 32'h0);
      t_pattern();
      t_hold();
      t_last();
      t_delay();
      t_repeat();
      end_of_test();
   end
endmodule // program_pattern_sequencer_tb
`default_nettype wire
